/* File: common/tms_consts.svh */
// constant offsets, field positions, reset values and timing for the timer
`ifndef TMS_CONSTS_SVH
`define TMS_CONSTS_SVH
`define TMS_ADDR_CTRL    4'h0
`define TMS_ADDR_LOAD    4'h1
`define TMS_ADDR_CMP     4'h2
`define TMS_ADDR_COUNT   4'h3
`define TMS_ADDR_CNT_NOW 4'h4
`define TMS_F_RUN        0
`define TMS_F_CMPIE      2
`define TMS_F_OVFIE      1
`define TMS_F_MODE_LO    4
`define TMS_F_INV        8
`define TMS_F_RELOAD     9
`define TMS_F_DIN        11
`define TMS_F_WRAP       13
`define TMS_F_CMP        14
`define TMS_F_PCE        15
`define TMS_CTRL_RST     16'h0000
`define TMS_CLK_NS       8
`endif

/* File: common/tms_pkg.sv */
// shared types for the timer mode sequencer
package tms_pkg;
  // mode field encodings
  typedef enum logic [3:0] {
    TMS_M_CMP    = 4'h0,
    TMS_M_PULSE  = 4'h1,
    TMS_M_TOGGLE = 4'h2,
    TMS_M_EVENT  = 4'h3,
    TMS_M_WIDTH  = 4'h4,
    TMS_M_PERIOD = 4'h5,
    TMS_M_CAPT   = 4'h6,
    TMS_M_PWM    = 4'h7,
    TMS_M_WDPUL  = 4'h9,
    TMS_M_WDTOG  = 4'hA
  } tms_mode_e;
  // counter phase
  typedef enum logic [1:0] {
    TMS_IDLE, TMS_ARMED, TMS_COUNT, TMS_HALT
  } tms_phase_e;
  typedef logic [15:0] tms_word_t;
endpackage

/* File: rtl/tms_timer.sv */
// one timer channel: mode sequencing, counter, flags and pin control
`timescale 1ns/1ps
`include "tms_consts.svh"
module tms_timer #(
  parameter int WIDTH = 16  // counter width
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [3:0]        addr,
  input  wire logic [15:0]       wrData,
  input  wire logic              wrStb,
  input  wire logic              rdStb,
  output logic [15:0]            rdData,
  input  wire logic              prescaleTick,
  input  wire logic              pinIn,
  output logic                   pinOut,
  output logic                   pinOe,
  input  wire logic              cmpAck,
  input  wire logic              ovfAck,
  output logic                   cmpIrq,
  output logic                   ovfIrq
);
  import tms_pkg::*;

  // whole state of the channel
  typedef struct packed {
    logic [15:0]     ctrl;     // control bits
    tms_word_t       load;     // load value
    tms_word_t       cmp;      // compare value
    tms_word_t       capt;     // count register
    logic [WIDTH-1:0] cnt;     // running counter
    tms_phase_e      phase;    // sequencing phase
    logic            div2;     // half-clock divider
    logic            pinS1;    // pin sync stage 1
    logic            pinS2;    // pin sync stage 2
    logic            pinS3;    // previous synced pin
    logic            matched;  // measured edge seen, reload next pulse
    logic            resync;   // armed phase: load on next pulse
    logic            pin;      // pin output level
    logic            pulseEnd; // end pulse on next tick
    logic [15:0]     rd;       // read data
    logic            cIrq;     // compare irq out
    logic            oIrq;     // overflow irq out
    logic            oe;       // pin drive enable
  } tms_state_s;

  tms_state_s st_reg;    // registered state
  tms_state_s st_next;   // next state
  logic       run;       // run bit
  logic       polarity_bit;       // polarity bit
  logic       rel;       // reload bit
  tms_mode_e  mode;      // decoded mode field
  logic       tick;      // timer pulse
  logic       pinLvl;    // synchronized pin
  logic       actEdge;   // qualifying edge
  logic       oppEdge;   // opposite edge
  logic       outMode;   // pin is output
  logic       mMatch;    // counter equals compare
  logic       isTimer;   // timer style mode
  logic [WIDTH-1:0] nxtCnt; // counter step result

  assign run = st_reg.ctrl[`TMS_F_RUN];
  assign polarity_bit = st_reg.ctrl[`TMS_F_INV];
  assign rel = st_reg.ctrl[`TMS_F_RELOAD];
  assign mode = tms_mode_e'(st_reg.ctrl[`TMS_F_MODE_LO +: 4]);
  assign pinLvl = st_reg.pinS2;
  assign actEdge = (st_reg.pinS3 ^ polarity_bit) == 1'b0 && (pinLvl ^ polarity_bit) == 1'b1;
  assign oppEdge = (st_reg.pinS3 ^ polarity_bit) == 1'b1 && (pinLvl ^ polarity_bit) == 1'b0;
  assign outMode = mode == TMS_M_PULSE || mode == TMS_M_TOGGLE ||
                   mode == TMS_M_PWM || mode == TMS_M_WDPUL ||
                   mode == TMS_M_WDTOG;
  assign isTimer = mode == TMS_M_CMP || outMode || mode == TMS_M_EVENT;
  assign mMatch = st_reg.cnt == st_reg.cmp[WIDTH-1:0];
  assign nxtCnt = st_reg.cnt + 1'b1;

  // timer pulse source selection
  always_comb begin
    if (st_reg.ctrl[`TMS_F_PCE]) begin
      tick = prescaleTick;
    // pin edges clock the event mode
    end else if (mode == TMS_M_EVENT) begin
      tick = actEdge;
    end else begin
      tick = st_reg.div2;
    end
  end

  // next-state logic
  always_comb begin
    logic runRise;  // run just set this cycle
    logic gateOk;   // width mode gate open
    logic setCmp;   // compare event
    logic setWrap;  // wrap event
    logic stepIt;   // counter advances
    runRise = 1'b0;
    gateOk  = 1'b0;
    setCmp  = 1'b0;
    setWrap = 1'b0;
    stepIt  = 1'b0;
    st_next = st_reg;
    // free-running divider and pin synchroniser
    // pinS1 feeds pinS2 only; two stages absorb a
    // metastable pin before any edge logic looks
    st_next.div2  = ~st_reg.div2;
    st_next.pinS1 = pinIn;
    st_next.pinS2 = st_reg.pinS1;
    st_next.pinS3 = st_reg.pinS2;
    st_next.cIrq  = 1'b0;
    st_next.oIrq  = 1'b0;
    st_next.rd = 16'h0000;
    if (rdStb) begin
      case (addr)
        `TMS_ADDR_CTRL: begin
          st_next.rd = st_reg.ctrl;
          st_next.rd[`TMS_F_DIN] = pinLvl ^ polarity_bit;
        end
        `TMS_ADDR_LOAD:    st_next.rd = st_reg.load;
        `TMS_ADDR_CMP:     st_next.rd = st_reg.cmp;
        `TMS_ADDR_COUNT:   st_next.rd = st_reg.capt;
        `TMS_ADDR_CNT_NOW: st_next.rd = 16'(st_reg.cnt);
        default:           st_next.rd = 16'h0000;
      endcase
    end
    // register writes
    if (wrStb) begin
      case (addr)
        `TMS_ADDR_CTRL: begin
          runRise = wrData[`TMS_F_RUN] & ~run;
          st_next.ctrl = wrData;
          st_next.ctrl[`TMS_F_DIN] = 1'b0;
          // bit 3 is reserved and reads as zero
          st_next.ctrl[3] = 1'b0;
          st_next.ctrl[`TMS_F_WRAP] = st_reg.ctrl[`TMS_F_WRAP] &
                                      ~wrData[`TMS_F_WRAP];
          st_next.ctrl[`TMS_F_CMP]  = st_reg.ctrl[`TMS_F_CMP] &
                                      ~wrData[`TMS_F_CMP];
        end
        `TMS_ADDR_LOAD: st_next.load = wrData;
        `TMS_ADDR_CMP:  st_next.cmp  = wrData;
        default: begin
        end
      endcase
    end
    // acknowledge clears
    // a set further down in this cycle still wins
    if (cmpAck) st_next.ctrl[`TMS_F_CMP] = 1'b0;
    if (ovfAck) st_next.ctrl[`TMS_F_WRAP] = 1'b0;
    // sequencing
    if (!st_next.ctrl[`TMS_F_RUN]) begin
      st_next.ctrl[`TMS_F_CMP]  = 1'b0;
      st_next.ctrl[`TMS_F_WRAP] = 1'b0;
      st_next.phase   = TMS_IDLE;
      st_next.matched = 1'b0;
      st_next.pulseEnd = 1'b0;
    end else if (runRise) begin
      st_next.cnt     = '0;
      st_next.phase   = TMS_ARMED;
      st_next.matched = 1'b0;
      st_next.resync  = 1'b0;
      st_next.pin = wrData[`TMS_F_INV];
    end else begin
      case (st_reg.phase)
        TMS_ARMED: begin
          case (mode)
            TMS_M_WIDTH, TMS_M_PERIOD: if (actEdge) st_next.resync = 1'b1;
            default: st_next.resync = 1'b1;
          endcase
          if (st_reg.resync && tick) begin
            st_next.cnt    = st_reg.load[WIDTH-1:0];
            st_next.phase  = TMS_COUNT;
            st_next.resync = 1'b0;
          end
        end
        TMS_COUNT: begin
          gateOk = mode != TMS_M_WIDTH || (pinLvl ^ polarity_bit);
          stepIt = tick && gateOk;
          if (stepIt) begin
            // reload on the pulse leaving a match
            // (timer modes) or after a measured edge
            if (rel && (st_reg.matched || (isTimer && mMatch))) begin
              st_next.cnt = st_reg.load[WIDTH-1:0];
            end else begin
              st_next.cnt = nxtCnt;
              setWrap = &st_reg.cnt;
            end
            st_next.matched = 1'b0;
          end
          if (isTimer && mMatch && stepIt && !st_reg.matched) begin
            // match in timer modes
            // flags on the pulse that leaves the compare
            // value, the same pulse that reloads
            setCmp = 1'b1;
            if (mode == TMS_M_PULSE) begin
              st_next.pin = ~polarity_bit;
              st_next.pulseEnd = 1'b1;
            end else if (mode == TMS_M_TOGGLE || mode == TMS_M_PWM) begin
              st_next.pin = ~st_reg.pin;
            end
          end else if (st_reg.pulseEnd && stepIt) begin
            st_next.pin = polarity_bit;
            st_next.pulseEnd = 1'b0;
          end
          if (mode == TMS_M_WIDTH && oppEdge) begin
            setCmp = 1'b1;
            st_next.capt = 16'(st_reg.cnt);
            st_next.phase = TMS_HALT;
          end
          if (mode == TMS_M_PERIOD && actEdge) begin
            setCmp = 1'b1;
            st_next.capt = 16'(st_reg.cnt);
            st_next.matched = 1'b1;
          end
          if (mode == TMS_M_CAPT && actEdge) begin
            setCmp = 1'b1;
            st_next.capt = 16'(st_reg.cnt);
            st_next.phase = TMS_HALT;
          end
        end
        TMS_HALT: begin
          if (mode == TMS_M_WIDTH && actEdge) begin
            st_next.matched = 1'b1;
            st_next.phase   = TMS_COUNT;
          end
        end
        default: st_next.phase = TMS_IDLE;
      endcase
    end
    if (setCmp) begin
      st_next.ctrl[`TMS_F_CMP] = 1'b1;
      st_next.cIrq = st_reg.ctrl[`TMS_F_CMPIE];
    end
    if (setWrap) begin
      st_next.ctrl[`TMS_F_WRAP] = 1'b1;
      st_next.oIrq = st_reg.ctrl[`TMS_F_OVFIE];
    end
    // pin drive follows run in output modes
    st_next.oe = st_next.ctrl[`TMS_F_RUN] && outMode;
  end

  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs from flops
  assign rdData = st_reg.rd;
  assign pinOut = st_reg.pin;
  assign cmpIrq = st_reg.cIrq;
  assign ovfIrq = st_reg.oIrq;
  assign pinOe  = st_reg.oe;
endmodule // tms_timer

/* File: verif/tms_pin_model.sv */
// outside source and load on the timer pin
`timescale 1ns/1ps
module tms_pin_model (
  input  wire logic clk,
  input  wire logic pinOut,
  input  wire logic pinOe,
  output logic      pinIn
);
  logic srcLevel = 1'b0;  // level the outside source drives
  // device wins the wire while it drives
  assign pinIn = pinOe ? pinOut : srcLevel;
  // edges kept at least four core clocks apart
  task automatic pulses(input int n, input int hold);
    repeat (n) begin
      repeat (hold < 4 ? 4 : hold) @(posedge clk);
      srcLevel <= 1'b1;
      repeat (hold < 4 ? 4 : hold) @(posedge clk);
      srcLevel <= 1'b0;
    end
  endtask
endmodule  // tms_pin_model

/* File: verif/tms_timer_checker.sv */
// port-level assertions for the timer channel
`timescale 1ns/1ps
module tms_timer_checker (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [3:0]  addr,
  input wire logic [15:0] wrData,
  input wire logic        wrStb,
  input wire logic        rdStb,
  input wire logic [15:0] rdData,
  input wire logic        pinOut,
  input wire logic        pinOe,
  input wire logic        cmpIrq,
  input wire logic        ovfIrq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [15:0] ctrl_reg;  // last control word written
  logic        inMode;    // mode field holds an input mode
  // shadow of the control word
  always_ff @(posedge clk) begin
    if (rst) ctrl_reg <= 16'h0000;
    else if (wrStb && addr == 4'h0) ctrl_reg <= wrData;
  end
  assign inMode = ctrl_reg[7:4] inside {4'h3, 4'h4, 4'h5, 4'h6};
  // run raised in pulse or toggle mode
  sequence run_start;
    $rose(ctrl_reg[0]) && ctrl_reg[7:4] inside {4'h1, 4'h2};
  endsequence
  // run held low for two cycles
  sequence run_off;
    !ctrl_reg[0] [*2];
  endsequence
  rd_idle_a: assert property (!$past(rdStb) |-> rdData == 16'h0000)
    else $error("read data outside its slot");
  unmapped_zero_a: assert property (rdStb && addr > 4'h4 |=> !rdData)
    else $error("unmapped read not zero");
  cmp_gate_a: assert property (cmpIrq |-> $past(ctrl_reg[2]))
    else $error("compare irq while disabled");
  ovf_gate_a: assert property (ovfIrq |-> $past(ctrl_reg[1]))
    else $error("overflow irq while disabled");
  ovf_pulse_a: assert property (ovfIrq |=> !ovfIrq)
    else $error("overflow irq wider than one cycle");
  input_oe_a: assert property (inMode && $stable(inMode) |-> !pinOe)
    else $error("pin driven in an input mode");
  cmp_pulse_a: assert property (cmpIrq |=> !cmpIrq)
    else $error("compare irq wider than one cycle");
  oe_off_a: assert property (run_off |-> !pinOe)
    else $error("pin driven while stopped");
  oe_on_a: assert property (run_start |-> ##[0:2] pinOe)
    else $error("pin not driven after run");
  pin_preset_a: assert property (run_start |-> ##[0:2] pinOut == ctrl_reg[8])
    else $error("pin not preset to polarity");
endmodule  // tms_timer_checker

/* File: verif/tms_timer_tb.sv */
// self-checking bench for the timer channel
`timescale 1ns/1ps
`include "tms_consts.svh"
module testbench;
  import tms_pkg::*;
  logic        clk, rst, wrStb, rdStb, pinIn, pinOut, pinOe;
  logic        ovfAck, cmpIrq, ovfIrq, cmpAck, prescaleTick;
  logic [3:0]  addr;
  logic [15:0] wrData, rdData, a, b;
  int          errTotal, checks, cyc, irqCnt, highCnt, ovfCnt;
  tms_timer DUT (.clk(clk), .rst(rst), .addr(addr), .wrData(wrData),
    .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
    .prescaleTick(prescaleTick), .pinIn(pinIn), .pinOut(pinOut),
    .pinOe(pinOe), .cmpAck(cmpAck),
    .ovfAck(ovfAck), .cmpIrq(cmpIrq), .ovfIrq(ovfIrq));
  tms_pin_model pin (.clk(clk), .pinOut(pinOut), .pinOe(pinOe),
    .pinIn(pinIn));
  // core clock
  initial begin
    clk = 1'b0;
    forever #(`TMS_CLK_NS / 2.0) clk = ~clk;
  end
  // cycle ceiling and event counts
  always @(posedge clk) begin
    cyc++;
    if (cmpIrq === 1'b1) irqCnt++;
    if (pinOut === 1'b1) highCnt++;
    if (ovfIrq === 1'b1) ovfCnt++;
    // prescaled tick every fourth cycle
    prescaleTick <= cyc % 4 == 3;
    if (cyc == 20000) begin
      errTotal++;
      end_sim();
    end
  end
  task automatic wr(input logic [3:0] ad, input logic [15:0] d);
    addr <= ad;
    wrData <= d;
    wrStb <= 1'b1;
    @(posedge clk);
    wrStb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] ad, output logic [15:0] d);
    addr <= ad;
    rdStb <= 1'b1;
    @(posedge clk);
    rdStb <= 1'b0;
    #1;
    d = rdData;
    @(posedge clk);
  endtask
  // stop, then run with a fresh control word
  task automatic start(input logic [15:0] w);
    wr(4'h0, 16'h0000);
    wr(4'h0, w);
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      errTotal++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim();
    if (errTotal == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    {wrStb, rdStb, ovfAck, cmpAck, addr, wrData} = '0;
    rst = 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(4'h0, a);
    chk("ctrlReset", a, `TMS_CTRL_RST);
    rd(4'hF, a);
    chk("unmapped", a, 16'h0000);
    // mode 0: flags, irq, ack, live count
    wr(4'h1, 16'hFFF0);
    wr(4'h2, 16'hFFF2);
    irqCnt = 0;
    wr(4'h0, 16'h0007);
    repeat (60) @(posedge clk);
    rd(4'h0, a);
    chk("bothFlags", a, 16'h6007);
    chk("cmpIrqs", 16'(irqCnt), 16'h0001);
    chk("ovfIrqs", 16'(ovfCnt), 16'h0001);
    ovfAck <= 1'b1;
    @(posedge clk);
    ovfAck <= 1'b0;
    rd(4'h0, a);
    chk("ackClear", a, 16'h4007);
    wr(4'h0, 16'h4007);
    rd(4'h0, a);
    chk("w1cClear", a, 16'h0007);
    rd(4'h4, a);
    repeat (8) @(posedge clk);
    rd(4'h4, b);
    chk("liveStep", b - a, 16'h0005);
    // reload keeps the count between load and compare
    wr(4'h1, 16'h0010);
    wr(4'h2, 16'h0013);
    start(16'h0201);
    repeat (4) @(posedge clk);
    for (int i = 0; i < 12; i++) begin
      rd(4'h4, a);
      chk("reload", 16'(a inside {[16'h0010:16'h0013]}), 16'h0001);
    end
    wr(4'h0, 16'h0000);
    rd(4'h0, a);
    chk("stopClear", a, 16'h0000);
    // toggle mode, both polarities, then pulse mode width
    wr(4'h1, 16'hFFF0);
    wr(4'h2, 16'hFFF8);
    for (int p = 0; p < 2; p++) begin
      start({7'h00, p[0], TMS_M_TOGGLE, 4'h1});
      repeat (3) @(posedge clk);
      chk("preset", {14'h0, pinOe, pinOut}, {15'h0001, p[0]});
      repeat (40) @(posedge clk);
      chk("toggled", 16'(pinOut), 16'(!p[0]));
    end
    start({8'h00, TMS_M_PULSE, 4'h1});
    highCnt = 0;
    repeat (40) @(posedge clk);
    chk("pulseWidth", 16'(highCnt), 16'h0002);
    // event count and capture, both polarities
    wr(4'h1, 16'h0100);
    for (int p = 0; p < 2; p++) begin
      start({7'h00, p[0], TMS_M_EVENT, 4'h1});
      pin.pulses(5, 6);
      repeat (8) @(posedge clk);
      rd(4'h4, a);
      chk("events", a, 16'h0104);
      start({7'h00, p[0], TMS_M_CAPT, 4'h1});
      repeat (20) @(posedge clk);
      pin.pulses(1, 6);
      repeat (8) @(posedge clk);
      rd(4'h4, a);
      repeat (6) @(posedge clk);
      rd(4'h4, b);
      chk("captStop", b - a, 16'h0000);
      rd(4'h0, a);
      chk("captFlag", a, {4'h4, p[0], 2'b00, p[0], 8'h61});
    end
    // width mode with reload: two high pulses
    start(16'h0245);
    irqCnt = 0;
    pin.pulses(2, 20);
    repeat (8) @(posedge clk);
    rd(4'h3, a);
    chk("widthCapt", 16'(a inside {[16'h0107:16'h010A]}), 16'h0001);
    chk("widthIrqs", 16'(irqCnt), 16'h0002);
    rd(4'h4, b);
    chk("widthHalt", b, a);
    rd(4'h0, a);
    chk("widthFlag", a, 16'h4245);
    cmpAck <= 1'b1;
    @(posedge clk);
    cmpAck <= 1'b0;
    rd(4'h0, a);
    chk("cmpAck", a, 16'h0245);
    // period between falling edges, reload each time
    start(16'h0355);
    irqCnt = 0;
    pin.pulses(3, 10);
    repeat (8) @(posedge clk);
    rd(4'h3, a);
    chk("period", 16'(a inside {[16'h0107:16'h010A]}), 16'h0001);
    chk("periodIrqs", 16'(irqCnt), 16'h0002);
    // prescaled clock replaces the half clock
    start(16'h8001);
    repeat (6) @(posedge clk);
    rd(4'h4, a);
    repeat (18) @(posedge clk);
    rd(4'h4, b);
    chk("prescale", b - a, 16'h0005);
    end_sim();
  end
endmodule  // testbench
bind tms_timer tms_timer_checker u_chk (.clk(clk), .rst(rst), .addr(addr),
  .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
  .pinOut(pinOut), .pinOe(pinOe), .cmpIrq(cmpIrq), .ovfIrq(ovfIrq));
